//--- smse_defs.svh
// Constants for the management-mode entry and state-save block
`ifndef SMSE_DEFS_SVH
`define SMSE_DEFS_SVH

// ----------------------------------------------------------------------------
// Configuration control register 1 bit positions
// ----------------------------------------------------------------------------
`define SMSE_CONFIG_CONTROL_REG1_USE_BIT 1
`define SMSE_CONFIG_CONTROL_REG1_NACC_BIT 2
`define SMSE_CONFIG_CONTROL_REG1_SPACE_BIT 7

// ----------------------------------------------------------------------------
// Region range size field
// ----------------------------------------------------------------------------
`define SMSE_SIZE_OFF 4'h0
`define SMSE_SIZE_4G 4'hf
`define SMSE_SIZE_SHIFT_BASE 6'd11
`define SMSE_BYTES_4G 33'h1_0000_0000
`define SMSE_CS_LIMIT 32'hffff_ffff

// ----------------------------------------------------------------------------
// Header pointer register
// ----------------------------------------------------------------------------
`define SMSE_PTR_VALID_BIT 0
`define SMSE_PTR_RES_BIT 1
`define SMSE_PTR_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// Header word indices, counted downward from the header pointer
// ----------------------------------------------------------------------------
`define SMSE_HDR_DR7 4'h0
`define SMSE_HDR_EXTENDED_FLAGS_REG 4'h1
`define SMSE_HDR_CR0 4'h2
`define SMSE_HDR_CUR_IP 4'h3
`define SMSE_HDR_NEXT_IP 4'h4
`define SMSE_HDR_CS_SEL 4'h5
`define SMSE_HDR_CS_DESC_LO 4'h6
`define SMSE_HDR_CS_DESC_HI 4'h7
`define SMSE_HDR_FLAGS 4'h8
`define SMSE_HDR_IO_PORT 4'h9
`define SMSE_HDR_IO_DATA 4'ha
`define SMSE_HDR_STR_INDEX 4'hb
`define SMSE_HDR_LAST 4'hb

// ----------------------------------------------------------------------------
// Flags word and I/O word field positions
// ----------------------------------------------------------------------------
`define SMSE_FLAG_N 0
`define SMSE_FLAG_IS 1
`define SMSE_FLAG_H 2
`define SMSE_FLAG_S 3
`define SMSE_FLAG_P 4
`define SMSE_FLAG_I 5
`define SMSE_FLAG_C 6
`define SMSE_FLAG_CPL 8
`define SMSE_IO_SIZE_POS 16

// ----------------------------------------------------------------------------
// I/O size codes
// ----------------------------------------------------------------------------
`define SMSE_IO_CODE_BYTE 8'h01
`define SMSE_IO_CODE_WORD 8'h03
`define SMSE_IO_CODE_DWORD 8'h0f

`endif

//--- smse_pkg.sv
// Types shared by the management-mode entry and state-save block
package smse_pkg;

    typedef enum logic [1:0] {
        smse_io_byte,
        smse_io_word,
        smse_io_dword
    } smse_io_size_t;

    typedef struct packed {
        logic [31:0] debug_control_reg7;
        logic [31:0] extended_flags_reg;
        logic [31:0] control_reg0;
        logic [31:0] cur_ip;
        logic [31:0] next_ip;
        logic [15:0] cs_selector;
        logic [63:0] cs_descriptor;
        logic [1:0] privilege_level_field;
        logic halted;
        logic cs_writable;
    } smse_cpu_state_t;

    typedef struct packed {
        logic valid;
        logic rep;
        logic write;
        smse_io_size_t size;
        logic [15:0] port;
        logic [31:0] data;
        logic [31:0] string_index_reg;
    } smse_io_trap_t;

endpackage

//--- smse_edge_sync.sv
// Two-stage synchroniser with falling-edge detect for the request pin
`timescale 1ns/100ps
`default_nettype none
module smse_edge_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Pin and event
    input wire logic pin_n,
    output logic fall_pulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= pin_n;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= sync_q;
        end
    end

    assign fall_pulse = prev_q & ~sync_q;
endmodule
`default_nettype wire

//--- smse_entry_save.sv
// Management-mode entry, header pointer and saved-state header writer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "smse_defs.svh"
module smse_entry_save
    import smse_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Entry requests
    input wire logic mgmt_request_pin_n,
    input wire logic soft_mgmt_entry_op,
    input wire logic insn_boundary,
    input wire logic internal_request,
    // Configuration
    input wire logic [7:0] config_control_reg1,
    input wire logic [19:0] mgmt_region_base,
    input wire logic [3:0] mgmt_region_size,
    input wire logic region_range_wr,
    // Processor state at the boundary
    input wire smse_cpu_state_t cpu_state,
    input wire smse_io_trap_t io_trap,
    // Header pointer and resume ops
    input wire logic read_header_ptr_op,
    input wire logic write_header_ptr_op,
    input wire logic [31:0] header_ptr_wr_data,
    output logic [31:0] header_ptr_rd_data,
    input wire logic resume_op,
    output logic [31:0] resume_ip,
    output logic resume_done,
    output logic invalid_opcode,
    // Header memory port
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // Mode outputs
    output logic entry_taken,
    output logic entry_busy,
    output logic mgmt_pending,
    output logic smm_active,
    output logic state_reset,
    output logic fetch_start,
    output logic [31:0] fetch_addr,
    output logic [31:0] cs_base,
    output logic [31:0] cs_limit,
    output logic real_mode,
    output logic addr20_unmask,
    output logic region_defined,
    output logic region_access_ok
);
    typedef enum logic [2:0] {
        smse_st_idle,
        smse_st_ptr,
        smse_st_save,
        smse_st_launch,
        smse_st_rd_ip,
        smse_st_rd_flags
    } smse_state_t;

    smse_state_t state_q;
    smse_cpu_state_t snap_q;
    smse_io_trap_t io_q;
    logic [31:0] ptr_q;
    logic [31:0] ptr_calc;
    logic [32:0] region_bytes;
    logic [3:0] idx_q;
    logic pin_fall;
    logic pin_pend_q;
    logic soft_q;
    logic is_q;
    logic nested_q;
    logic smm_q;
    logic use_ok;
    logic pin_ok;
    logic soft_ok;
    logic priv_ok;
    logic accept;
    logic take_pin;
    logic ptr_load;
    logic ptr_wr;
    logic resume_go;
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic [31:0] resume_ip_q;
    logic resume_done_q;
    logic invalid_q;
    logic [31:0] rd_data_q;

    // ------------------------------------------------------------------------
    // Recognition and priority
    // ------------------------------------------------------------------------
    smse_edge_sync u_pin_sync (
        .clock(clock),
        .reset(reset),
        .pin_n(mgmt_request_pin_n),
        .fall_pulse(pin_fall)
    );

    assign use_ok = config_control_reg1[`SMSE_CONFIG_CONTROL_REG1_USE_BIT] & config_control_reg1[`SMSE_CONFIG_CONTROL_REG1_SPACE_BIT]
        & (mgmt_region_size != `SMSE_SIZE_OFF);
    assign pin_ok = use_ok & ~config_control_reg1[`SMSE_CONFIG_CONTROL_REG1_NACC_BIT];
    assign soft_ok = use_ok & config_control_reg1[`SMSE_CONFIG_CONTROL_REG1_NACC_BIT];
    assign priv_ok = use_ok & (cpu_state.privilege_level_field == 2'b00)
        & (config_control_reg1[`SMSE_CONFIG_CONTROL_REG1_NACC_BIT] | smm_q);
    assign take_pin = pin_pend_q;
    assign accept = (state_q == smse_st_idle) & insn_boundary
        & (take_pin | (soft_mgmt_entry_op & soft_ok));
    assign resume_go = (state_q == smse_st_idle) & ~accept & resume_op & priv_ok & smm_q;
    assign ptr_load = (state_q == smse_st_ptr) & ~ptr_q[`SMSE_PTR_VALID_BIT];
    assign ptr_wr = (state_q == smse_st_idle) & write_header_ptr_op & priv_ok;

    // Pending pin edge; a new edge wins over the clear on acceptance
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pin_pend_q <= 1'b0;
        end else if (pin_fall & pin_ok) begin
            pin_pend_q <= 1'b1;
        end else if (accept & take_pin) begin
            pin_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Entry snapshot and cause flags
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            snap_q <= '0;
            io_q <= '0;
            soft_q <= 1'b0;
            is_q <= 1'b0;
            nested_q <= 1'b0;
        end else if (accept) begin
            snap_q <= cpu_state;
            io_q <= io_trap;
            soft_q <= ~take_pin;
            is_q <= take_pin ? internal_request : 1'b1;
            nested_q <= smm_q;
        end
    end

    // ------------------------------------------------------------------------
    // Header pointer register
    // ------------------------------------------------------------------------
    assign region_bytes = (mgmt_region_size == `SMSE_SIZE_4G) ? `SMSE_BYTES_4G
        : (33'h1 << (`SMSE_SIZE_SHIFT_BASE + {2'b00, mgmt_region_size}));
    assign ptr_calc = 32'({1'b0, mgmt_region_base, 12'h000} + region_bytes);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ptr_q <= `SMSE_PTR_RESET;
        end else if (ptr_load) begin
            ptr_q <= {ptr_calc[31:2], 2'b01};
        end else if (ptr_wr) begin
            ptr_q <= {header_ptr_wr_data[31:2], 1'b0, header_ptr_wr_data[0]};
        end else if (region_range_wr) begin
            ptr_q[`SMSE_PTR_VALID_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rd_data_q <= '0;
            invalid_q <= 1'b0;
        end else begin
            if ((state_q == smse_st_idle) & read_header_ptr_op & priv_ok) begin
                rd_data_q <= ptr_q;
            end
            invalid_q <= (read_header_ptr_op & ~priv_ok) | (write_header_ptr_op & ~priv_ok)
                | (resume_op & ~(priv_ok & smm_q)) | (soft_mgmt_entry_op & ~soft_ok);
        end
    end

    // ------------------------------------------------------------------------
    // Header word contents
    // ------------------------------------------------------------------------
    function automatic logic [7:0] io_code(input smse_io_size_t sz);
        unique case (sz)
            smse_io_byte: io_code = `SMSE_IO_CODE_BYTE;
            smse_io_word: io_code = `SMSE_IO_CODE_WORD;
            default: io_code = `SMSE_IO_CODE_DWORD;
        endcase
    endfunction

    function automatic logic [31:0] hdr_addr(input logic [31:0] ptr, input logic [3:0] idx);
        hdr_addr = {ptr[31:2], 2'b00} - {26'h0, idx + 4'h1, 2'b00};
    endfunction

    function automatic logic [31:0] hdr_word(input logic [3:0] idx);
        logic [31:0] w;
        w = '0;
        unique case (idx)
            `SMSE_HDR_DR7: w = snap_q.debug_control_reg7;
            `SMSE_HDR_EXTENDED_FLAGS_REG: w = snap_q.extended_flags_reg;
            `SMSE_HDR_CR0: w = snap_q.control_reg0;
            `SMSE_HDR_CUR_IP: w = snap_q.cur_ip;
            `SMSE_HDR_NEXT_IP: w = (io_q.valid & io_q.rep) ? snap_q.cur_ip : snap_q.next_ip;
            `SMSE_HDR_CS_SEL: w = {16'h0000, snap_q.cs_selector};
            `SMSE_HDR_CS_DESC_LO: w = snap_q.cs_descriptor[31:0];
            `SMSE_HDR_CS_DESC_HI: w = snap_q.cs_descriptor[63:32];
            `SMSE_HDR_FLAGS: begin
                w[`SMSE_FLAG_N] = nested_q;
                w[`SMSE_FLAG_IS] = is_q;
                w[`SMSE_FLAG_H] = snap_q.halted;
                w[`SMSE_FLAG_S] = soft_q;
                w[`SMSE_FLAG_P] = io_q.valid & io_q.rep;
                w[`SMSE_FLAG_I] = io_q.valid & io_q.write;
                w[`SMSE_FLAG_C] = snap_q.cs_writable;
                w[`SMSE_FLAG_CPL +: 2] = snap_q.privilege_level_field;
            end
            `SMSE_HDR_IO_PORT: begin
                if (io_q.valid) begin
                    w = {8'h00, io_code(io_q.size), io_q.port};
                end
            end
            `SMSE_HDR_IO_DATA: w = io_q.valid ? io_q.data : 32'h0;
            `SMSE_HDR_STR_INDEX: w = io_q.string_index_reg;
            default: w = '0;
        endcase
        hdr_word = w;
    endfunction

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= smse_st_idle;
            idx_q <= '0;
        end else begin
            unique case (state_q)
                smse_st_idle: begin
                    if (accept) begin
                        state_q <= smse_st_ptr;
                    end else if (resume_go) begin
                        state_q <= smse_st_rd_ip;
                    end
                end
                smse_st_ptr: begin
                    state_q <= smse_st_save;
                    idx_q <= '0;
                end
                smse_st_save: begin
                    if (mem_ack) begin
                        if (idx_q == `SMSE_HDR_LAST) begin
                            state_q <= smse_st_launch;
                        end else begin
                            idx_q <= idx_q + 4'h1;
                        end
                    end
                end
                smse_st_launch: state_q <= smse_st_idle;
                smse_st_rd_ip: begin
                    if (mem_ack) begin
                        state_q <= smse_st_rd_flags;
                    end
                end
                smse_st_rd_flags: begin
                    if (mem_ack) begin
                        state_q <= smse_st_idle;
                    end
                end
            endcase
        end
    end

    // Memory address and data registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            addr_q <= '0;
            wdata_q <= '0;
        end else if (state_q == smse_st_ptr) begin
            addr_q <= hdr_addr(ptr_load ? {ptr_calc[31:2], 2'b01} : ptr_q, `SMSE_HDR_DR7);
            wdata_q <= hdr_word(`SMSE_HDR_DR7);
        end else if ((state_q == smse_st_save) & mem_ack & (idx_q != `SMSE_HDR_LAST)) begin
            addr_q <= hdr_addr(ptr_q, idx_q + 4'h1);
            wdata_q <= hdr_word(idx_q + 4'h1);
        end else if (resume_go) begin
            addr_q <= hdr_addr(ptr_q, `SMSE_HDR_NEXT_IP);
        end else if ((state_q == smse_st_rd_ip) & mem_ack) begin
            addr_q <= hdr_addr(ptr_q, `SMSE_HDR_FLAGS);
        end
    end

    // Mode, resume pointer and resume completion
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            smm_q <= 1'b0;
            resume_ip_q <= '0;
            resume_done_q <= 1'b0;
        end else begin
            resume_done_q <= (state_q == smse_st_rd_flags) & mem_ack;
            if (state_q == smse_st_launch) begin
                smm_q <= 1'b1;
            end else if ((state_q == smse_st_rd_flags) & mem_ack) begin
                smm_q <= mem_rdata[`SMSE_FLAG_N];
            end
            if ((state_q == smse_st_rd_ip) & mem_ack) begin
                resume_ip_q <= mem_rdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign mem_req = (state_q == smse_st_save) | (state_q == smse_st_rd_ip) | (state_q == smse_st_rd_flags);
    assign mem_we = (state_q == smse_st_save);
    assign mem_addr = addr_q;
    assign mem_wdata = wdata_q;
    assign header_ptr_rd_data = rd_data_q;
    assign invalid_opcode = invalid_q;
    assign resume_ip = resume_ip_q;
    assign resume_done = resume_done_q;
    assign entry_taken = accept;
    assign entry_busy = (state_q != smse_st_idle);
    assign mgmt_pending = pin_pend_q | entry_busy;
    assign smm_active = smm_q;
    assign state_reset = (state_q == smse_st_launch);
    assign fetch_start = (state_q == smse_st_launch);
    assign fetch_addr = {mgmt_region_base, 12'h000};
    assign cs_base = {mgmt_region_base, 12'h000};
    assign cs_limit = `SMSE_CS_LIMIT;
    assign real_mode = (state_q == smse_st_launch);
    assign addr20_unmask = smm_q | entry_busy;
    assign region_defined = use_ok;
    assign region_access_ok = use_ok & (smm_q | entry_busy | config_control_reg1[`SMSE_CONFIG_CONTROL_REG1_NACC_BIT]);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_last_write;
        (state_q == smse_st_save) && mem_ack && (idx_q == `SMSE_HDR_LAST);
    endsequence
    sequence s_launch;
        fetch_start && state_reset;
    endsequence

    property p_pin_priority;
        accept && pin_pend_q && soft_mgmt_entry_op |=> !soft_q && (state_q == smse_st_ptr);
    endproperty
    a_pin_priority: assert property (p_pin_priority) else $error("soft entry beat pin");
    property p_soft_path;
        (state_q == smse_st_idle) && insn_boundary && !pin_pend_q && soft_mgmt_entry_op && soft_ok
            |=> soft_q && (state_q == smse_st_ptr);
    endproperty
    a_soft_path: assert property (p_soft_path) else $error("soft entry not taken");
    property p_no_recog;
        pin_fall && !pin_ok && !pin_pend_q |=> !pin_pend_q;
    endproperty
    a_no_recog: assert property (p_no_recog) else $error("pin taken while disabled");
    property p_region_closed;
        !smm_q && !entry_busy && !config_control_reg1[`SMSE_CONFIG_CONTROL_REG1_NACC_BIT] |-> !region_access_ok;
    endproperty
    a_region_closed: assert property (p_region_closed) else $error("region open in normal mode");
    property p_ptr_clear;
        region_range_wr && !ptr_load && !ptr_wr |=> !ptr_q[`SMSE_PTR_VALID_BIT];
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("valid not cleared");
    property p_ptr_load;
        ptr_load |=> ptr_q[`SMSE_PTR_VALID_BIT] && (ptr_q[31:2] == $past(ptr_calc[31:2]));
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not computed");
    property p_writes_first;
        s_last_write |=> s_launch;
    endproperty
    a_writes_first: assert property (p_writes_first) else $error("fetch not after save");
    property p_fetch_after_save;
        fetch_start |-> $past(state_q == smse_st_save) && $past(mem_ack);
    endproperty
    a_fetch_after_save: assert property (p_fetch_after_save) else $error("fetch before save done");
    property p_rep_same_ip;
        mem_req && mem_we && (idx_q == `SMSE_HDR_NEXT_IP) && io_q.valid && io_q.rep |-> mem_wdata == snap_q.cur_ip;
    endproperty
    a_rep_same_ip: assert property (p_rep_same_ip) else $error("rep trap pointers differ");
    property p_resume_ip;
        (state_q == smse_st_rd_ip) && mem_ack |=> resume_ip == $past(mem_rdata) ##1 1'b1;
    endproperty
    a_resume_ip: assert property (p_resume_ip) else $error("resume pointer wrong");
    property p_a20;
        smm_q |-> addr20_unmask;
    endproperty
    a_a20: assert property (p_a20) else $error("address bit 20 masked");
endmodule
`default_nettype wire

//--- smse_mem_model.sv
// Header memory partner with random acknowledge delay
`timescale 1ns/100ps
`default_nettype none
module smse_mem_model (
    // Clock and memory port
    input wire logic clock,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [logic [31:0]];
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    always @(posedge clock) begin
        mem_ack <= mem_req && !mem_ack && ($urandom % 2 == 0);
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && mem_we) mem[mem_addr] = mem_wdata;
        if (mem_req && !mem_ack && !mem_we && mem.exists(mem_addr)) mem_rdata <= mem[mem_addr];
    end
endmodule
`default_nettype wire

//--- smse_entry_save_tb_top.sv
// Self-checking bench for the management-mode entry block
`timescale 1ns/100ps
`default_nettype none
module smse_entry_save_tb_top import smse_pkg::*;;
logic clock, reset, mgmt_request_pin_n, soft_mgmt_entry_op, insn_boundary, internal_request, region_range_wr;
logic read_header_ptr_op, write_header_ptr_op, resume_op, resume_done, invalid_opcode, mem_req, mem_we, mem_ack;
logic entry_taken, smm_active, state_reset, fetch_start, entry_busy, mgmt_pending, real_mode, addr20_unmask;
logic region_defined, region_access_ok;
logic [31:0] cs_base, cs_limit;
logic [3:0] ev;
logic [7:0] config_control_reg1;
logic [19:0] mgmt_region_base;
logic [3:0] mgmt_region_size;
logic [31:0] header_ptr_wr_data, header_ptr_rd_data, resume_ip, mem_addr, mem_wdata, mem_rdata, fetch_addr, p;
smse_cpu_state_t cpu_state;
smse_io_trap_t io_trap;
int bad_count = 0;
int check_count = 0;
assign ev = {invalid_opcode, resume_done, fetch_start, entry_taken};
smse_entry_save DUT (.clock, .reset, .mgmt_request_pin_n, .soft_mgmt_entry_op, .insn_boundary, .internal_request,
    .config_control_reg1, .mgmt_region_base, .mgmt_region_size, .region_range_wr, .cpu_state, .io_trap,
    .read_header_ptr_op, .write_header_ptr_op, .header_ptr_wr_data, .header_ptr_rd_data, .resume_op, .resume_ip,
    .resume_done, .invalid_opcode, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .entry_taken,
    .entry_busy, .mgmt_pending, .smm_active, .state_reset, .fetch_start, .fetch_addr, .cs_base, .cs_limit,
    .real_mode, .addr20_unmask, .region_defined, .region_access_ok);
smse_mem_model MEM (.clock, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
function automatic logic [31:0] wa(input int i);
    return p - 32'(4 * (i + 1));
endfunction
function automatic logic [31:0] fl(input logic n, input logic is, input logic s);
    return {22'h0, cpu_state.privilege_level_field, 1'b0, cpu_state.cs_writable, io_trap.write, io_trap.rep, s,
        cpu_state.halted, is, n};
endfunction
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
        bad_count++;
        $display("Error %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic complete_run();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task automatic wt(input int w);
    int n;
    #1;
    for (n = 0; n < 300 && ev[w] !== 1'b1; n++) begin
        @(posedge clock);
        #1;
    end
    chk("event", 32'h1, 32'(ev[w]));
endtask
task automatic op(input int k);
    @(posedge clock);
    {region_range_wr, resume_op, write_header_ptr_op, read_header_ptr_op} <= 4'(1 << k);
    @(posedge clock);
    {region_range_wr, resume_op, write_header_ptr_op, read_header_ptr_op} <= 4'h0;
    #1;
endtask
task automatic rnd_state();
    cpu_state <= '{$urandom, $urandom, $urandom, $urandom, $urandom, 16'($urandom), {$urandom, $urandom},
        2'($urandom), 1'($urandom), 1'($urandom)};
endtask
task automatic hdr(input logic n, input logic is, input logic s);
    chk("dr7", cpu_state.debug_control_reg7, MEM.mem[wa(0)]);
    chk("next_ip", io_trap.rep ? cpu_state.cur_ip : cpu_state.next_ip, MEM.mem[wa(4)]);
    chk("flags", fl(n, is, s), MEM.mem[wa(8)]);
    chk("io", !io_trap.valid ? 32'h0 : {8'h0, io_trap.size == smse_io_byte ? 8'h01 : io_trap.size == smse_io_word ?
        8'h03 : 8'h0f, io_trap.port}, MEM.mem[wa(9)]);
    chk("str_idx", io_trap.string_index_reg, MEM.mem[wa(11)]);
endtask
initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
end
initial begin
    #100000;
    bad_count++;
    complete_run();
end
initial begin
    void'($urandom(74));
    {reset, mgmt_request_pin_n, insn_boundary} = 3'b111;
    {soft_mgmt_entry_op, region_range_wr, read_header_ptr_op, write_header_ptr_op, resume_op} = 5'h0;
    internal_request = 1'($urandom);
    config_control_reg1 = 8'h82;
    mgmt_region_size = 4'($urandom_range(14, 1));
    mgmt_region_base = 20'($urandom) & ~((20'h1 << (mgmt_region_size - 4'h1)) - 20'h1);
    p = {mgmt_region_base, 12'h0} + (32'h1 << (32'(mgmt_region_size) + 11));
    header_ptr_wr_data = $urandom | 32'h2;
    io_trap = '0;
    rnd_state();
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk("closed", 32'h0, 32'(region_access_ok));
    chk("defined", 32'h1, 32'(region_defined));
    chk("a20_idle", 32'h0, 32'(addr20_unmask));
    chk("idle", 32'h0, 32'({entry_busy, mgmt_pending}));
    @(posedge clock);
    mgmt_request_pin_n <= 1'b0;
    soft_mgmt_entry_op <= 1'b1;
    wt(1);
    chk("fetch", {mgmt_region_base, 12'h0}, fetch_addr);
    chk("state_reset", 32'h1, 32'(state_reset));
    chk("cs_base", {mgmt_region_base, 12'h0}, cs_base);
    chk("cs_limit", 32'hffff_ffff, cs_limit);
    chk("real_mode", 32'h1, 32'(real_mode));
    chk("a20_busy", 32'h1, 32'(addr20_unmask));
    chk("open", 32'h1, 32'(region_access_ok));
    chk("busy", 32'h3, 32'({entry_busy, mgmt_pending}));
    hdr(1'b0, internal_request, 1'b0);
    @(posedge clock);
    mgmt_request_pin_n <= 1'b1;
    soft_mgmt_entry_op <= 1'b0;
    cpu_state.privilege_level_field <= 2'h0;
    op(0);
    chk("ptr", p | 32'h1, header_ptr_rd_data);
    @(posedge clock);
    rnd_state();
    io_trap <= '{1'b1, 1'b1, 1'($urandom), smse_io_size_t'($urandom_range(2, 0)), 16'($urandom), $urandom, $urandom};
    config_control_reg1 <= 8'h86;
    soft_mgmt_entry_op <= 1'b1;
    wt(0);
    @(posedge clock);
    soft_mgmt_entry_op <= 1'b0;
    wt(1);
    hdr(1'b1, 1'b1, 1'b1);
    @(posedge clock);
    cpu_state.privilege_level_field <= 2'h0;
    op(2);
    wt(2);
    chk("resume_ip", cpu_state.cur_ip, resume_ip);
    chk("active", 32'h1, 32'(smm_active));
    op(1);
    op(0);
    chk("ptr_wr", {header_ptr_wr_data[31:2], 1'b0, header_ptr_wr_data[0]}, header_ptr_rd_data);
    op(3);
    op(0);
    chk("ptr_clr", {header_ptr_wr_data[31:2], 2'b00}, header_ptr_rd_data);
    @(posedge clock);
    mgmt_request_pin_n <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    chk("dropped", 32'h0, 32'(mgmt_pending));
    @(posedge clock);
    mgmt_request_pin_n <= 1'b1;
    config_control_reg1 <= 8'h82;
    soft_mgmt_entry_op <= 1'b1;
    wt(3);
    @(posedge clock);
    soft_mgmt_entry_op <= 1'b0;
    complete_run();
end
endmodule
`default_nettype wire
